/* File: include/wake_event_pkg.sv */
// package: register offsets, field positions and reset values of the wake event block
package wake_event_pkg;
   localparam logic [7:0] ADDR_STATUS      = 8'hF4;
   localparam logic [7:0] ADDR_EN_SERIAL   = 8'hF5;
   localparam logic [7:0] ADDR_EN_LEGACY   = 8'hF6;
   localparam logic [7:0] ADDR_EN_RING     = 8'hF7;
   localparam logic [7:0] ADDR_BATTERY     = 8'hF8;
   localparam logic [7:0] ADDR_GLOBAL      = 8'hE0;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'hE1;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'hE2;
   localparam logic [7:0] RESET_VALUE      = 8'h00;
   // implemented bits of the status register and the serial enable register
   localparam logic [7:0] STATUS_MASK      = 8'hFC;
   localparam logic [7:0] EN_SERIAL_MASK   = 8'hF0;
   // status bit positions
   localparam int BIT_SERIAL_C = 7;
   localparam int BIT_SERIAL_D = 6;
   localparam int BIT_SERIAL_E = 5;
   localparam int BIT_SERIAL_F = 4;
   localparam int BIT_HWMON    = 3;
   localparam int BIT_WATCHDOG = 2;
   // legacy enable positions
   localparam int BIT_KBMS_PASSWORD = 7;
   localparam int BIT_EN_RING_A     = 6;
   localparam int BIT_EN_MOUSE      = 5;
   localparam int BIT_EN_KEYBOARD   = 4;
   localparam int BIT_EN_PARALLEL   = 3;
   localparam int BIT_EN_FLOPPY     = 2;
   localparam int BIT_EN_SERIAL_A   = 1;
   localparam int BIT_EN_SERIAL_B   = 0;
   // ring and misc enable positions
   localparam int BIT_EN_RING_C     = 7;
   localparam int BIT_EN_RING_D     = 6;
   localparam int BIT_EN_RING_E     = 5;
   localparam int BIT_EN_INFRARED   = 4;
   localparam int BIT_EN_HWMON      = 3;
   localparam int BIT_EN_WATCHDOG   = 2;
   localparam int BIT_EN_RING_F     = 1;
   localparam int BIT_EN_RING_B     = 0;
   // interrupt status bits
   localparam int IRQ_BIT_EVENT     = 0;
   localparam int IRQ_BIT_WAKE      = 1;
   localparam logic [7:0] IRQ_MASK_BITS = 8'h03;
endpackage

/* File: design/wake_event_status_enable.sv */
// wake event status latching, enable gating and software register port
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - status F4 bits 7-4 latch serial C-F
// - status F4 bit 3 latches hardware monitor
// - bit 2 latches watchdog; bits 1-0 reserved
// - write one clears status; read shows status
// - F5 bits 7-4 enable serial C-F wake
// - F6 bit 7 enables keyboard/mouse password interrupt
// - F6 bits 6-0 enable legacy wake sources
// - F7 bits 7-0 enable ring/misc wake sources
// - F4-F7 reset to zero by standby reset
// - F8 battery nibbles reset by battery reset
// - global enable gates all wake signalling
//////////////////////////////////////////////////////////////////////////////
module wake_event_status_enable (
   // clock and resets
   input  wire logic        i_clock,
   input  wire logic        i_arst_n,
   input  wire logic        i_battery_arst_n,
   // register port
   input  wire logic [7:0]  i_address,
   input  wire logic [7:0]  i_write_data,
   input  wire logic        i_write,
   input  wire logic        i_read,
   output logic      [7:0]  o_read_data,
   // event sources latched in the status register
   input  wire logic        i_serial_port_c_irq,
   input  wire logic        i_serial_port_d_irq,
   input  wire logic        i_serial_port_e_irq,
   input  wire logic        i_serial_port_f_irq,
   input  wire logic        i_hardware_monitor_irq,
   input  wire logic        i_watchdog_one_event,
   // status bits of sources held elsewhere, one per enable, already latched
   input  wire logic [7:0]  i_legacy_status,
   input  wire logic [7:0]  i_ring_misc_status,
   // outputs
   output logic             o_wake_event,
   output logic             o_kbms_password_enable,
   output logic [7:0]       o_battery_config,
   output logic             o_irq
);

   //////////////////////////////////////////////////////////////////////////
   // legacy enables that gate wake; bit 7 steers the password interrupt only
   localparam logic [7:0] LEGACY_WAKE_BITS = ~(8'h01 << wake_event_pkg::BIT_KBMS_PASSWORD);

   // software registers
   logic [7:0] wake_event_status_b;
   logic [7:0] wake_enable_serial_hi;
   logic [7:0] wake_enable_legacy;
   logic [7:0] wake_enable_ring_misc;
   logic [7:0] battery_backed_config;
   logic       global_wake_enable;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   // write decode, one hit per register
   logic       hit_status;
   logic       hit_en_serial;
   logic       hit_en_legacy;
   logic       hit_en_ring;
   logic       hit_battery;
   logic       hit_global;
   logic       hit_irq_status;
   logic       hit_irq_mask;
   // events and next values
   logic [7:0] event_in;
   logic [7:0] next_status;
   logic       new_event;
   logic       wake_serial;
   logic       wake_misc;
   logic       wake_legacy;
   logic       wake_ring;
   logic       next_wake;
   logic       wake_previous;
   logic [7:0] irq_event;
   logic [7:0] next_irq_status;
   logic [7:0] next_read_data;

   //////////////////////////////////////////////////////////////////////////
   // true when the strobe is high and the address selects the target register
   function automatic logic is_write(input logic [7:0] address, input logic [7:0] target, input logic strobe);
      return strobe && (address == target);
   endfunction

   // true when any status bit has its enable bit set
   function automatic logic any_enabled(input logic [7:0] status, input logic [7:0] enable);
      return |(status & enable);
   endfunction

   // write one to clear; a set in the same cycle wins so that no event is lost
   function automatic logic [7:0] clear_then_set(input logic [7:0] current, input logic [7:0] clear_bits,
                                                 input logic hit, input logic [7:0] set_bits);
      logic [7:0] kept;
      kept = hit ? (current & ~clear_bits) : current;
      return kept | set_bits;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // write decode
   always_comb begin
      hit_status     = is_write(i_address, wake_event_pkg::ADDR_STATUS, i_write);
      hit_en_serial  = is_write(i_address, wake_event_pkg::ADDR_EN_SERIAL, i_write);
      hit_en_legacy  = is_write(i_address, wake_event_pkg::ADDR_EN_LEGACY, i_write);
      hit_en_ring    = is_write(i_address, wake_event_pkg::ADDR_EN_RING, i_write);
      hit_battery    = is_write(i_address, wake_event_pkg::ADDR_BATTERY, i_write);
      hit_global     = is_write(i_address, wake_event_pkg::ADDR_GLOBAL, i_write);
      hit_irq_status = is_write(i_address, wake_event_pkg::ADDR_IRQ_STATUS, i_write);
      hit_irq_mask   = is_write(i_address, wake_event_pkg::ADDR_IRQ_MASK, i_write);
   end

   //////////////////////////////////////////////////////////////////////////
   // status register, standby well
   // sources are levels; a bit keeps setting while its source stays high
   always_comb begin
      event_in = wake_event_pkg::RESET_VALUE;
      event_in[wake_event_pkg::BIT_SERIAL_C] = i_serial_port_c_irq;
      event_in[wake_event_pkg::BIT_SERIAL_D] = i_serial_port_d_irq;
      event_in[wake_event_pkg::BIT_SERIAL_E] = i_serial_port_e_irq;
      event_in[wake_event_pkg::BIT_SERIAL_F] = i_serial_port_f_irq;
      event_in[wake_event_pkg::BIT_HWMON]    = i_hardware_monitor_irq;
      event_in[wake_event_pkg::BIT_WATCHDOG] = i_watchdog_one_event;
   end

   always_comb begin
      next_status = clear_then_set(wake_event_status_b, i_write_data, hit_status, event_in) &
                    wake_event_pkg::STATUS_MASK;
      new_event   = |(event_in & ~wake_event_status_b);
   end

   // the standby resume reset is the only reset of this well
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wake_event_status_b <= wake_event_pkg::RESET_VALUE;
      end else begin
         wake_event_status_b <= next_status;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // enable registers, standby well
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wake_enable_serial_hi <= wake_event_pkg::RESET_VALUE;
      end else if (hit_en_serial) begin
         wake_enable_serial_hi <= i_write_data & wake_event_pkg::EN_SERIAL_MASK;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wake_enable_legacy <= wake_event_pkg::RESET_VALUE;
      end else if (hit_en_legacy) begin
         wake_enable_legacy <= i_write_data;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wake_enable_ring_misc <= wake_event_pkg::RESET_VALUE;
      end else if (hit_en_ring) begin
         wake_enable_ring_misc <= i_write_data;
      end
   end

   // the global enable and the interrupt mask are this block's own, also in the standby well
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         global_wake_enable <= 1'b0;
      end else if (hit_global) begin
         global_wake_enable <= i_write_data[0];
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_mask <= wake_event_pkg::RESET_VALUE;
      end else if (hit_irq_mask) begin
         irq_mask <= i_write_data & wake_event_pkg::IRQ_MASK_BITS;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // battery well: only the battery reset returns the register, and its output copy, to zero
   always_ff @(posedge i_clock or negedge i_battery_arst_n) begin
      if (!i_battery_arst_n) begin
         battery_backed_config <= wake_event_pkg::RESET_VALUE;
         o_battery_config      <= wake_event_pkg::RESET_VALUE;
      end else begin
         o_battery_config <= battery_backed_config;
         if (hit_battery) begin
            battery_backed_config <= i_write_data;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // wake output: legacy and ring/misc status arrive already latched from their own registers
   always_comb begin
      wake_serial = any_enabled(wake_event_status_b, wake_enable_serial_hi);
      wake_misc   = (wake_event_status_b[wake_event_pkg::BIT_HWMON] &&
                     wake_enable_ring_misc[wake_event_pkg::BIT_EN_HWMON]) ||
                    (wake_event_status_b[wake_event_pkg::BIT_WATCHDOG] &&
                     wake_enable_ring_misc[wake_event_pkg::BIT_EN_WATCHDOG]);
      wake_legacy = any_enabled(i_legacy_status, wake_enable_legacy & LEGACY_WAKE_BITS);
      wake_ring   = any_enabled(i_ring_misc_status, wake_enable_ring_misc);
      next_wake   = global_wake_enable && (wake_serial || wake_misc || wake_legacy || wake_ring);
   end

   // wake_previous marks the rising wake condition for the interrupt
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_wake_event  <= 1'b0;
         wake_previous <= 1'b0;
      end else begin
         o_wake_event  <= next_wake;
         wake_previous <= next_wake;
      end
   end

   // registered copy of the password bit
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_kbms_password_enable <= 1'b0;
      end else begin
         o_kbms_password_enable <= wake_enable_legacy[wake_event_pkg::BIT_KBMS_PASSWORD];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // interrupt: bit 0 any new status event, bit 1 rising wake condition
   always_comb begin
      irq_event = wake_event_pkg::RESET_VALUE;
      irq_event[wake_event_pkg::IRQ_BIT_EVENT] = new_event;
      irq_event[wake_event_pkg::IRQ_BIT_WAKE]  = next_wake && !wake_previous;
      next_irq_status = clear_then_set(irq_status, i_write_data, hit_irq_status, irq_event) &
                        wake_event_pkg::IRQ_MASK_BITS;
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_status <= wake_event_pkg::RESET_VALUE;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   // the level output lags the status by a cycle so that it leaves from a flip-flop
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= any_enabled(irq_status, irq_mask);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // read port: unmapped addresses and idle cycles read as zero
   always_comb begin
      next_read_data = wake_event_pkg::RESET_VALUE;
      if (i_read) begin
         unique case (i_address)
            wake_event_pkg::ADDR_STATUS: begin
               next_read_data = wake_event_status_b;
            end
            wake_event_pkg::ADDR_EN_SERIAL: begin
               next_read_data = wake_enable_serial_hi;
            end
            wake_event_pkg::ADDR_EN_LEGACY: begin
               next_read_data = wake_enable_legacy;
            end
            wake_event_pkg::ADDR_EN_RING: begin
               next_read_data = wake_enable_ring_misc;
            end
            wake_event_pkg::ADDR_BATTERY: begin
               next_read_data = battery_backed_config;
            end
            wake_event_pkg::ADDR_GLOBAL: begin
               next_read_data = {7'h00, global_wake_enable};
            end
            wake_event_pkg::ADDR_IRQ_STATUS: begin
               next_read_data = irq_status;
            end
            wake_event_pkg::ADDR_IRQ_MASK: begin
               next_read_data = irq_mask;
            end
            default: begin
               next_read_data = wake_event_pkg::RESET_VALUE;
            end
         endcase
      end
   end

   // read data stand for exactly one cycle after the strobe
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_read_data <= wake_event_pkg::RESET_VALUE;
      end else begin
         o_read_data <= next_read_data;
      end
   end

endmodule

/* File: testbench/wake_event_sva.sv */
// assertions on the register port and outputs of the wake event block
`timescale 1ns/10ps
module wake_event_sva (
   // clock, reset and register port
   input wire logic       i_clock,
   input wire logic       i_arst_n,
   input wire logic [7:0] i_address,
   input wire logic [7:0] i_write_data,
   input wire logic       i_write,
   input wire logic       i_read,
   input wire logic [7:0] o_read_data,
   // sources and outputs
   input wire logic       i_serial_port_c_irq,
   input wire logic       i_hardware_monitor_irq,
   input wire logic       o_wake_event,
   input wire logic       o_kbms_password_enable,
   input wire logic [7:0] o_battery_config
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   sequence rd_status; i_read && i_address == 8'hF4; endsequence
   sequence c_seen; i_serial_port_c_irq ##1 !i_write; endsequence
   sequence c_clear; i_write && i_address == 8'hF4 && i_write_data[7] && !i_serial_port_c_irq; endsequence
   //////////////////////////////////////////////////////////////////////////////
   read_idle_a: assert property (!i_read |=> o_read_data == 8'h00) else $error("read data not idle");
   status_rsvd_a: assert property (rd_status |=> o_read_data[1:0] == 2'b00) else $error("status low bits");
   serial_rsvd_a: assert property (i_read && i_address == 8'hF5 |=> o_read_data[3:0] == 4'h0)
      else $error("serial enable low bits");
   serial_set_a: assert property (c_seen ##1 rd_status |=> o_read_data[7]) else $error("serial c not latched");
   hwmon_set_a: assert property (i_hardware_monitor_irq ##1 !i_write ##1 rd_status |=> o_read_data[3])
      else $error("monitor not latched");
   clear_one_a: assert property (c_clear ##1 !i_serial_port_c_irq ##1 rd_status |=> !o_read_data[7])
      else $error("status not cleared");
   password_copy_a: assert property (i_write && i_address == 8'hF6 |-> ##2 o_kbms_password_enable == $past(i_write_data[7], 2))
      else $error("password enable wrong");
   battery_copy_a: assert property (i_write && i_address == 8'hF8 |-> ##2 o_battery_config == $past(i_write_data, 2))
      else $error("battery copy wrong");
   wake_reset_a: assert property ($rose(i_arst_n) |-> !o_wake_event) else $error("wake after reset");
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the wake event block
`timescale 1ns/10ps
module tb;
   logic       i_clock = 0, i_arst_n = 0, i_battery_arst_n = 0, i_write = 0, i_read = 0, rd_q1 = 0;
   logic [7:0] i_address = 8'h00, i_write_data = 8'h00, i_legacy_status = 8'h00, i_ring_misc_status = 8'h00;
   logic [5:0] src = 6'h00;
   logic [7:0] o_read_data, o_battery_config, v;
   logic       o_wake_event, o_kbms_password_enable, o_irq;
   logic [7:0] exp_q[$];
   int         failures = 0, samples_checked = 0, cycles = 0;
   localparam logic [7:0] MSK [4] = '{8'hF0, 8'hFF, 8'hFF, 8'hFF};
   wake_event_status_enable wake_event_status_enable_inst (.i_clock, .i_arst_n, .i_battery_arst_n, .i_address,
      .i_write_data, .i_write, .i_read, .o_read_data, .i_serial_port_c_irq(src[5]), .i_serial_port_d_irq(src[4]),
      .i_serial_port_e_irq(src[3]), .i_serial_port_f_irq(src[2]), .i_hardware_monitor_irq(src[1]),
      .i_watchdog_one_event(src[0]), .i_legacy_status, .i_ring_misc_status, .o_wake_event,
      .o_kbms_password_enable, .o_battery_config, .o_irq);
   initial begin
      forever #20 i_clock = ~i_clock;
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask
   task automatic tally_and_finish;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_write <= 1'b1; i_address <= a; i_write_data <= d;
      @(posedge i_clock);
      i_write <= 1'b0;
   endtask
   // the expected byte is queued with the strobe; the monitor below pops it
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clock);
      i_read <= 1'b1; i_address <= a; exp_q.push_back(e);
      @(posedge i_clock);
      i_read <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   always @(posedge i_clock) begin
      rd_q1 <= i_read;
      cycles++;
      if (cycles == 5000) begin
         failures++;
         tally_and_finish();
      end
   end
   // read data stand only in the cycle after the strobe
   always @(negedge i_clock) if (rd_q1) chk(o_read_data, exp_q.pop_front());
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h9bbf30bb));
      repeat (20) @(posedge i_clock);
      i_arst_n <= 1'b1; i_battery_arst_n <= 1'b1;
      for (int a = 'hF4; a <= 'hF8; a++) rd(a[7:0], 8'h00);
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'h00);
      for (int k = 0; k < 4; k++) begin
         v = 8'($urandom);
         wr(8'hF5 + k[7:0], v);
         rd(8'hF5 + k[7:0], v & MSK[k]);
      end
      idle(1);
      chk(o_battery_config, v);
      wr(8'hF6, 8'h80);
      idle(2);
      chk({7'h00, o_kbms_password_enable}, 8'h01);
      for (int k = 0; k < 6; k++) begin
         @(posedge i_clock) src <= 6'h01 << k;
         @(posedge i_clock) src <= 6'h00;
         rd(8'hF4, 8'h04 << k);
         wr(8'hF4, 8'h04 << k);
      end
      rd(8'hF4, 8'h00);
      @(posedge i_clock) src <= 6'h3F;
      @(posedge i_clock) src <= 6'h00;
      v = 8'($urandom);
      wr(8'hF4, v);
      rd(8'hF4, 8'hFC & ~v);
      wr(8'hF4, 8'hFF);
      wr(8'hF5, 8'h80);
      wr(8'hF7, 8'h00);
      wr(8'hE2, 8'h02);
      wr(8'hE0, 8'h01);
      @(posedge i_clock) src <= 6'h20;
      @(posedge i_clock) src <= 6'h00;
      idle(4);
      chk({6'h00, o_wake_event, o_irq}, 8'h03);
      wr(8'hE1, 8'h02);
      wr(8'hE0, 8'h00);
      idle(3);
      chk({6'h00, o_wake_event, o_irq}, 8'h00);
      wr(8'hF4, 8'h80);
      wr(8'hE0, 8'h01);
      wr(8'hF6, 8'h02);
      i_legacy_status <= 8'h02;
      idle(3);
      chk({7'h00, o_wake_event}, 8'h01);
      wr(8'hF6, 8'h00);
      wr(8'hF7, 8'h80);
      idle(2);
      chk({7'h00, o_wake_event}, 8'h00);
      @(posedge i_clock) i_ring_misc_status <= 8'h80;
      idle(3);
      chk({7'h00, o_wake_event}, 8'h01);
      wr(8'hF8, 8'hA5);
      @(posedge i_clock) i_arst_n <= 1'b0;
      idle(1);
      chk(o_battery_config, 8'hA5);
      @(posedge i_clock) i_arst_n <= 1'b1;
      rd(8'hF6, 8'h00);
      rd(8'hF8, 8'hA5);
      @(posedge i_clock) i_battery_arst_n <= 1'b0;
      @(posedge i_clock) i_battery_arst_n <= 1'b1;
      rd(8'hF8, 8'h00);
      idle(3);
      tally_and_finish();
   end
endmodule
bind wake_event_status_enable wake_event_sva wake_event_sva_inst (.i_clock, .i_arst_n, .i_address, .i_write_data,
   .i_write, .i_read, .o_read_data, .i_serial_port_c_irq, .i_hardware_monitor_irq, .o_wake_event,
   .o_kbms_password_enable, .o_battery_config);
